// ===== inc/rlec_pkg.sv
// Register map, field positions, reset values and timing counts of the equalizer control bank
package rlec_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_LIU_CFG = 8'h20;
  localparam logic [7:0] ADDR_RX_CFG = 8'h22;
  localparam logic [7:0] ADDR_LPF = 8'h23;
  localparam logic [7:0] ADDR_CEIL = 8'h24;
  localparam logic [7:0] ADDR_COEF_DATA = 8'h25;
  localparam logic [7:0] ADDR_COEF_PTR = 8'h26;
  localparam logic [7:0] ADDR_SLICE = 8'h27;
  localparam logic [7:0] ADDR_LEVEL = 8'h28;
  localparam logic [7:0] ADDR_GAIN = 8'h29;
  localparam logic [7:0] ADDR_PREEQ = 8'h2A;
  localparam logic [7:0] ADDR_ADJ_BASE = 8'h30;
  localparam logic [7:0] ADDR_ADJ_LAST = 8'h37;

  // Line interface configuration, soft reset bit
  localparam int LIU_RST_BIT = 7;

  // Receive line configuration fields
  localparam int CFG_SHORT_FRZ = 7;
  localparam int CFG_HI_SLICE = 6;
  localparam int CFG_AGC_HI = 5;
  localparam int CFG_AGC_LO = 4;
  localparam int CFG_COEF_FRZ = 3;
  localparam int CFG_OOR_BLK = 2;
  localparam int CFG_BO_EN = 1;
  localparam int CFG_LONG_EYE = 0;

  // Slicer threshold fields
  localparam int SLICE_MAX_HI = 7;
  localparam int SLICE_MAX_LO = 6;
  localparam int SLICE_MIN_HI = 5;
  localparam int SLICE_MIN_LO = 4;
  localparam int SLICE_THR_HI = 3;

  // Output level fields
  localparam int LEVEL_ACQ_HI = 7;
  localparam int LEVEL_ACQ_LO = 6;
  localparam int LEVEL_OP_HI = 5;
  localparam int LEVEL_OP_LO = 4;
  localparam int LEVEL_PULSE_HI = 3;

  // Pre-equalizer fields
  localparam int PREEQ_FORCE = 7;
  localparam int PREEQ_ON = 6;
  localparam int PREEQ_VTH_HI = 5;

  // Reset values
  localparam logic [7:0] CFG_RST = 8'h31;
  localparam logic [6:0] LPF_RST = 7'h40;
  localparam logic [5:0] CEIL_RST = 6'h3F;
  localparam logic [7:0] COEF_RST = 8'h00;
  localparam logic [5:0] PTR_RST = 6'h00;
  localparam logic [7:0] SLICE_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'hDA;
  localparam logic [7:0] PREEQ_RST = 8'h00;
  localparam logic [5:0] GAIN_RST = 6'h00;

  // Gain update windows in bit times: 32, 128, 512, 2048
  localparam logic [11:0] AGC_WIN_0 = 12'h020;
  localparam logic [11:0] AGC_WIN_1 = 12'h080;
  localparam logic [11:0] AGC_WIN_2 = 12'h200;
  localparam logic [11:0] AGC_WIN_3 = 12'h800;

  // Short eye-open timeout in bit times, 4096
  localparam logic [13:0] EYE_SHORT_BITS = 14'h1000;

  // Eye error tolerances in percent: 13, 19, 26, 32
  localparam logic [6:0] EYE_TOL_0 = 7'h0D;
  localparam logic [6:0] EYE_TOL_1 = 7'h13;
  localparam logic [6:0] EYE_TOL_2 = 7'h1A;
  localparam logic [6:0] EYE_TOL_3 = 7'h20;

  // Target pulse heights in percent: 61, 68, 74, 81
  localparam logic [3:0] PULSE_CODE_61 = 4'h9;
  localparam logic [3:0] PULSE_CODE_68 = 4'hA;
  localparam logic [3:0] PULSE_CODE_74 = 4'hB;
  localparam logic [3:0] PULSE_CODE_81 = 4'hC;
  localparam logic [6:0] PULSE_PCT_61 = 7'h3D;
  localparam logic [6:0] PULSE_PCT_68 = 7'h44;
  localparam logic [6:0] PULSE_PCT_74 = 7'h4A;
  localparam logic [6:0] PULSE_PCT_81 = 7'h51;

endpackage

// ===== design/rlec_eq_ctrl.sv
// Receive line equalizer control and status register bank
module rlec_eq_ctrl #(
  parameter int COEF_ENTRIES = 48,
  parameter int EYE_LONG_BITS = 8192
) (
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Equalizer core status
  input wire logic bit_tick,
  input wire logic rx_level_short,
  input wire logic adc_out_of_range,
  input wire logic eye_open,
  input wire logic eq_tracking,
  input wire logic [6:0] eq_error_pct,
  input wire logic [5:0] vga_gain_request,
  input wire logic [5:0] vga_gain_now,
  input wire logic pre_equalizer_auto_on,
  input wire logic [7:0][7:0] adjusted_coefficient,
  // Equalizer core controls
  output logic eq_update_en,
  output logic agc_update,
  output logic build_out_switch_en,
  output logic attenuation_forced_off,
  output logic high_clock_slice_threshold,
  output logic [5:0] vga_gain_cmd,
  output logic [6:0] loop_filter_gain,
  output logic [1:0] agc_max_value,
  output logic [1:0] agc_min_value,
  output logic [3:0] data_slice_threshold,
  output logic [6:0] target_pulse_pct,
  output logic [6:0] eye_tolerance_pct,
  output logic pre_equalizer_on,
  output logic [5:0] pre_filter_threshold,
  output logic eye_timeout,
  output logic eq_restart,
  output logic line_interface_soft_reset,
  output logic [COEF_ENTRIES*8-1:0] coefficient_table
);

  // Register storage
  logic [7:0] cfg_q;
  logic [6:0] lpf_q;
  logic [5:0] ceil_q;
  logic [5:0] ptr_q;
  logic [7:0] coef_q [COEF_ENTRIES];
  logic [7:0] slice_q;
  logic [7:0] level_q;
  logic [5:0] gain_q;
  logic [7:0] preeq_q;
  logic soft_rst_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  // Core control state
  logic upd_en_q;
  logic agc_upd_q;
  logic [11:0] agc_cnt_q;
  logic bo_en_q;
  logic atten_off_q;
  logic [5:0] gain_cmd_q;
  logic [6:0] tol_q;
  logic [6:0] pulse_q;
  logic pre_on_q;
  logic [13:0] eye_cnt_q;
  logic eye_to_q;
  logic restart_q;
  logic reload;
  logic ptr_valid;
  logic [6:0] tol_now;
  logic [13:0] eye_limit;

  function automatic logic [11:0] agc_period(input logic [1:0] code);
    case (code)
      2'b00: agc_period = rlec_pkg::AGC_WIN_0;
      2'b01: agc_period = rlec_pkg::AGC_WIN_1;
      2'b10: agc_period = rlec_pkg::AGC_WIN_2;
      default: agc_period = rlec_pkg::AGC_WIN_3;
    endcase
  endfunction

  function automatic logic [6:0] eye_tol(input logic [1:0] code);
    case (code)
      2'b00: eye_tol = rlec_pkg::EYE_TOL_0;
      2'b01: eye_tol = rlec_pkg::EYE_TOL_1;
      2'b10: eye_tol = rlec_pkg::EYE_TOL_2;
      default: eye_tol = rlec_pkg::EYE_TOL_3;
    endcase
  endfunction

  function automatic logic [6:0] pulse_pct(input logic [3:0] code);
    case (code)
      rlec_pkg::PULSE_CODE_61: pulse_pct = rlec_pkg::PULSE_PCT_61;
      rlec_pkg::PULSE_CODE_74: pulse_pct = rlec_pkg::PULSE_PCT_74;
      rlec_pkg::PULSE_CODE_81: pulse_pct = rlec_pkg::PULSE_PCT_81;
      default: pulse_pct = rlec_pkg::PULSE_PCT_68;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] addr, input logic wr);
    wr_hit = wr && (addr == a);
  endfunction

  assign reload = rst || soft_rst_q;
  assign ptr_valid = 32'(ptr_q) < COEF_ENTRIES;
  // Tolerance follows the adaptation state
  assign tol_now = eq_tracking ? eye_tol(level_q[rlec_pkg::LEVEL_OP_HI:rlec_pkg::LEVEL_OP_LO])
                               : eye_tol(level_q[rlec_pkg::LEVEL_ACQ_HI:rlec_pkg::LEVEL_ACQ_LO]);
  assign eye_limit = cfg_q[rlec_pkg::CFG_LONG_EYE] ? 14'(EYE_LONG_BITS) : rlec_pkg::EYE_SHORT_BITS;

  // Soft reset pulse, self-clearing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_hit(rlec_pkg::ADDR_LIU_CFG, reg_addr, reg_wr) && reg_wdata[rlec_pkg::LIU_RST_BIT];
    end
  end

  // Chip-reset-only registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= rlec_pkg::CFG_RST;
      lpf_q <= rlec_pkg::LPF_RST;
      ceil_q <= rlec_pkg::CEIL_RST;
      level_q <= rlec_pkg::LEVEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == rlec_pkg::ADDR_RX_CFG) begin
        cfg_q <= reg_wdata;
      end
      if (reg_addr == rlec_pkg::ADDR_LPF) begin
        lpf_q <= reg_wdata[6:0];
      end
      if (reg_addr == rlec_pkg::ADDR_CEIL) begin
        ceil_q <= reg_wdata[5:0];
      end
      if (reg_addr == rlec_pkg::ADDR_LEVEL) begin
        level_q <= reg_wdata;
      end
    end
  end

  // Registers reloaded by either reset
  always_ff @(posedge clk_sys) begin
    if (reload) begin
      ptr_q <= rlec_pkg::PTR_RST;
      slice_q <= rlec_pkg::SLICE_RST;
      preeq_q <= rlec_pkg::PREEQ_RST;
    end else if (reg_wr) begin
      if (reg_addr == rlec_pkg::ADDR_COEF_PTR) begin
        ptr_q <= reg_wdata[5:0];
      end
      if (reg_addr == rlec_pkg::ADDR_SLICE) begin
        slice_q <= reg_wdata;
      end
      if (reg_addr == rlec_pkg::ADDR_PREEQ) begin
        preeq_q <= reg_wdata;
      end
    end
  end

  // Coefficient table, writes past the last entry are dropped
  always_ff @(posedge clk_sys) begin
    if (reload) begin
      for (int i = 0; i < COEF_ENTRIES; i++) begin
        coef_q[i] <= rlec_pkg::COEF_RST;
      end
    end else if (wr_hit(rlec_pkg::ADDR_COEF_DATA, reg_addr, reg_wr) && ptr_valid) begin
      coef_q[ptr_q] <= reg_wdata;
    end
  end

  // Gain snapshot taken on any write to the gain register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_q <= rlec_pkg::GAIN_RST;
    end else if (wr_hit(rlec_pkg::ADDR_GAIN, reg_addr, reg_wr)) begin
      gain_q <= vga_gain_now;
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      rlec_pkg::ADDR_RX_CFG: rdata_d = cfg_q;
      rlec_pkg::ADDR_LPF: rdata_d = {1'b0, lpf_q};
      rlec_pkg::ADDR_CEIL: rdata_d = {2'b00, ceil_q};
      rlec_pkg::ADDR_COEF_DATA: rdata_d = ptr_valid ? coef_q[ptr_q] : 8'h00;
      rlec_pkg::ADDR_COEF_PTR: rdata_d = {2'b00, ptr_q};
      rlec_pkg::ADDR_SLICE: rdata_d = slice_q;
      rlec_pkg::ADDR_LEVEL: rdata_d = level_q;
      rlec_pkg::ADDR_GAIN: rdata_d = {2'b00, gain_q};
      rlec_pkg::ADDR_PREEQ: rdata_d = preeq_q;
      default: begin
        if (reg_addr >= rlec_pkg::ADDR_ADJ_BASE && reg_addr <= rlec_pkg::ADDR_ADJ_LAST) begin
          rdata_d = adjusted_coefficient[reg_addr[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // Equalizer update gating
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      upd_en_q <= 1'b0;
    end else begin
      upd_en_q <= !cfg_q[rlec_pkg::CFG_COEF_FRZ]
                  && !(cfg_q[rlec_pkg::CFG_SHORT_FRZ] && rx_level_short);
    end
  end

  // Gain update window, unaffected by coefficient freeze
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      agc_cnt_q <= 12'h000;
      agc_upd_q <= 1'b0;
    end else begin
      agc_upd_q <= 1'b0;
      if (bit_tick) begin
        if (agc_cnt_q >= agc_period(cfg_q[rlec_pkg::CFG_AGC_HI:rlec_pkg::CFG_AGC_LO]) - 12'h001) begin
          agc_cnt_q <= 12'h000;
          agc_upd_q <= 1'b1;
        end else begin
          agc_cnt_q <= agc_cnt_q + 12'h001;
        end
      end
    end
  end

  // Build-out switching and attenuation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bo_en_q <= 1'b0;
      atten_off_q <= 1'b1;
    end else begin
      bo_en_q <= cfg_q[rlec_pkg::CFG_BO_EN] && !(cfg_q[rlec_pkg::CFG_OOR_BLK] && adc_out_of_range);
      atten_off_q <= !cfg_q[rlec_pkg::CFG_BO_EN];
    end
  end

  // Gain clamp
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_cmd_q <= 6'h00;
    end else begin
      gain_cmd_q <= (vga_gain_request > ceil_q) ? ceil_q : vga_gain_request;
    end
  end

  // Pre-equalizer mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre_on_q <= 1'b0;
    end else begin
      pre_on_q <= preeq_q[rlec_pkg::PREEQ_FORCE] ? preeq_q[rlec_pkg::PREEQ_ON] : pre_equalizer_auto_on;
    end
  end

  // Eye-open timeout counter, counts only while the eye is closed
  always_ff @(posedge clk_sys) begin
    if (reload) begin
      eye_cnt_q <= 14'h0000;
      eye_to_q <= 1'b0;
    end else begin
      eye_to_q <= 1'b0;
      if (eye_open) begin
        eye_cnt_q <= 14'h0000;
      end else if (bit_tick) begin
        if (eye_cnt_q >= eye_limit - 14'h0001) begin
          eye_cnt_q <= 14'h0000;
          eye_to_q <= 1'b1;
        end else begin
          eye_cnt_q <= eye_cnt_q + 14'h0001;
        end
      end
    end
  end

  // Adaptation restart on excess error, timeout or soft reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      restart_q <= 1'b0;
      tol_q <= rlec_pkg::EYE_TOL_3;
      pulse_q <= rlec_pkg::PULSE_PCT_68;
    end else begin
      tol_q <= tol_now;
      pulse_q <= pulse_pct(level_q[rlec_pkg::LEVEL_PULSE_HI:0]);
      restart_q <= (eq_error_pct > tol_now) || eye_to_q || soft_rst_q;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign eq_update_en = upd_en_q;
  assign agc_update = agc_upd_q;
  assign build_out_switch_en = bo_en_q;
  assign attenuation_forced_off = atten_off_q;
  assign high_clock_slice_threshold = cfg_q[rlec_pkg::CFG_HI_SLICE];
  assign vga_gain_cmd = gain_cmd_q;
  assign loop_filter_gain = lpf_q;
  assign agc_max_value = slice_q[rlec_pkg::SLICE_MAX_HI:rlec_pkg::SLICE_MAX_LO];
  assign agc_min_value = slice_q[rlec_pkg::SLICE_MIN_HI:rlec_pkg::SLICE_MIN_LO];
  assign data_slice_threshold = slice_q[rlec_pkg::SLICE_THR_HI:0];
  assign target_pulse_pct = pulse_q;
  assign eye_tolerance_pct = tol_q;
  assign pre_equalizer_on = pre_on_q;
  assign pre_filter_threshold = preeq_q[rlec_pkg::PREEQ_VTH_HI:0];
  assign eye_timeout = eye_to_q;
  assign eq_restart = restart_q;
  assign line_interface_soft_reset = soft_rst_q;

  for (genvar g = 0; g < COEF_ENTRIES; g++) begin : g_tab
    assign coefficient_table[g*8 +: 8] = coef_q[g];
  end

  // Checks
  coef_freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q[rlec_pkg::CFG_COEF_FRZ] |=> !eq_update_en) else $error("update while frozen");
  short_freeze_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q[rlec_pkg::CFG_SHORT_FRZ] && rx_level_short |=> !eq_update_en) else $error("short line not frozen");
  free_update_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_q[rlec_pkg::CFG_COEF_FRZ] && !cfg_q[rlec_pkg::CFG_SHORT_FRZ] |=> eq_update_en)
    else $error("update blocked");
  agc_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    agc_update |-> $past(bit_tick) && ($past(agc_cnt_q) >= $past(agc_period(
      cfg_q[rlec_pkg::CFG_AGC_HI:rlec_pkg::CFG_AGC_LO])) - 12'h001)) else $error("gain window wrong");
  out_of_range_switch_block_a: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_q[rlec_pkg::CFG_OOR_BLK] && adc_out_of_range |=> !build_out_switch_en)
    else $error("build-out not blocked");
  atten_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_q[rlec_pkg::CFG_BO_EN] |=> attenuation_forced_off && !build_out_switch_en)
    else $error("attenuation not off");
  gain_cap_a: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> vga_gain_cmd <= $past(ceil_q)) else $error("gain above ceiling");
  coef_write_a: assert property (@(posedge clk_sys) disable iff (reload)
    reg_wr && reg_addr == rlec_pkg::ADDR_COEF_DATA && ptr_valid ##1 !reload
    |-> coef_q[$past(ptr_q)] == $past(reg_wdata)) else $error("coefficient not stored");
  soft_reload_a: assert property (@(posedge clk_sys) disable iff (rst)
    line_interface_soft_reset |=> ptr_q == rlec_pkg::PTR_RST && slice_q == rlec_pkg::SLICE_RST)
    else $error("soft reset no reload");
  soft_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == rlec_pkg::ADDR_LIU_CFG && reg_wdata[rlec_pkg::LIU_RST_BIT]
    |=> line_interface_soft_reset ##1 eq_restart) else $error("soft reset missing");
  gain_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == rlec_pkg::ADDR_GAIN |=> gain_q == $past(vga_gain_now)) else $error("gain readout stale");
  err_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    eq_error_pct > tol_now |=> eq_restart) else $error("no restart on error");
  preeq_force_a: assert property (@(posedge clk_sys) disable iff (rst)
    preeq_q[rlec_pkg::PREEQ_FORCE] |=> pre_equalizer_on == $past(preeq_q[rlec_pkg::PREEQ_ON]))
    else $error("pre-equalizer not forced");
  eye_timeout_a: assert property (@(posedge clk_sys) disable iff (reload)
    eye_timeout |-> $past(eye_cnt_q) == $past(eye_limit) - 14'h0001 && $past(!eye_open))
    else $error("eye timeout early");
endmodule

// ===== test/rlec_host_model.sv
// Host processor model on the parallel register port
module rlec_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse of their last value
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~x;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    x = reg_rdata;
  endtask
  // Gain readout needs a dummy write first
  task automatic gain(output logic [7:0] x);
    wr(8'h29, 8'hA5);
    rd(8'h29, x);
  endtask
  // Output level register back to its default
  task automatic level_default();
    wr(8'h28, 8'hDA);
  endtask
endmodule

// ===== test/test_rlec_eq_ctrl.sv
// Self-checking bench for the equalizer control register bank
module test_rlec_eq_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG_EYE = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic bit_tick = 1'b1;
  logic rx_level_short = 1'b0;
  logic adc_out_of_range = 1'b0;
  logic eye_open = 1'b1;
  logic eq_tracking = 1'b0;
  logic pre_equalizer_auto_on = 1'b0;
  logic [6:0] eq_error_pct = 7'h00;
  logic [5:0] vga_gain_request = 6'h00;
  logic [5:0] vga_gain_now = 6'h00;
  logic [7:0][7:0] adjusted_coefficient = '0;
  logic eq_update_en, agc_update, build_out_switch_en, attenuation_forced_off, high_clock_slice_threshold;
  logic pre_equalizer_on, eye_timeout, eq_restart, line_interface_soft_reset;
  logic [5:0] vga_gain_cmd, pre_filter_threshold, p;
  logic [6:0] loop_filter_gain, target_pulse_pct, eye_tolerance_pct, t;
  logic [1:0] agc_max_value, agc_min_value;
  logic [3:0] data_slice_threshold;
  logic [383:0] coefficient_table;
  logic [7:0] d, v;
  int error_cnt = 0;
  int checks_done = 0;
  int n;

  always #2 clk_sys = ~clk_sys;

  rlec_eq_ctrl #(.COEF_ENTRIES(48), .EYE_LONG_BITS(LONG_EYE)) i_rlec_eq_ctrl (
    .clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .bit_tick, .rx_level_short,
    .adc_out_of_range, .eye_open, .eq_tracking, .eq_error_pct, .vga_gain_request, .vga_gain_now,
    .pre_equalizer_auto_on, .adjusted_coefficient, .eq_update_en, .agc_update, .build_out_switch_en,
    .attenuation_forced_off, .high_clock_slice_threshold, .vga_gain_cmd, .loop_filter_gain, .agc_max_value,
    .agc_min_value, .data_slice_threshold, .target_pulse_pct, .eye_tolerance_pct, .pre_equalizer_on,
    .pre_filter_threshold, .eye_timeout, .eq_restart, .line_interface_soft_reset, .coefficient_table
  );
  rlec_host_model i_rlec_host_model (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

  task automatic final_report();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_n(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] x);
    i_rlec_host_model.wr(a, x);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    i_rlec_host_model.rd(a, x);
    cmp("readback", e, x);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask
  // Bounded wait for a pulse: 0 gain window, 1 eye timeout, 2 soft reset
  task automatic gap(input int s, input int lim, output int c);
    c = 0;
    while ((s == 0 ? agc_update : s == 1 ? eye_timeout : line_interface_soft_reset) !== 1'b1) begin
      @(negedge clk_sys);
      c++;
      if (c > lim) begin
        error_cnt++;
        final_report();
      end
    end
  endtask
  function automatic logic [6:0] tol_of(input logic [1:0] k);
    case (k)
      2'b00: return 7'h0D;
      2'b01: return 7'h13;
      2'b10: return 7'h1A;
      default: return 7'h20;
    endcase
  endfunction
  function automatic logic [6:0] pulse_of(input logic [3:0] k);
    case (k)
      4'h9: return 7'h3D;
      4'hB: return 7'h4A;
      4'hC: return 7'h51;
      default: return 7'h44;
    endcase
  endfunction

  initial begin
    n = $urandom(32'h8bcf);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, unmapped place, reset tolerance and pulse outputs
    rdc(8'h22, 8'h31);
    rdc(8'h23, {1'b0, rlec_pkg::LPF_RST});
    rdc(8'h24, 8'h3F);
    rdc(8'h26, 8'h00);
    rdc(8'h27, rlec_pkg::SLICE_RST);
    rdc(8'h28, 8'hDA);
    rdc(8'h2A, 8'h00);
    w(8'h21, 8'hFF);
    rdc(8'h21, 8'h00);
    cmp("tolerance", 8'h20, {1'b0, eye_tolerance_pct});
    cmp("pulse", 8'h44, {1'b0, target_pulse_pct});
    // Coefficient table through pointer, with both end entries
    for (int i = 0; i < 8; i++) begin
      p = (i == 0) ? 6'd47 : (i == 1) ? 6'd0 : 6'($urandom % 48);
      d = 8'($urandom);
      w(8'h26, {2'b00, p});
      w(8'h25, d);
      rdc(8'h26, {2'b00, p});
      rdc(8'h25, d);
      cmp("table", d, coefficient_table[8 * p +: 8]);
    end
    w(8'h26, 8'h30);
    w(8'h25, 8'h77);
    rdc(8'h25, 8'h00);
    // Gain snapshot is latched at the write, not live
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 6'h3F : 6'($urandom);
      @(posedge clk_sys);
      vga_gain_now <= p;
      fork
        i_rlec_host_model.gain(v);
        begin
          repeat (2) @(posedge clk_sys);
          vga_gain_now <= ~p;
        end
      join
      cmp("gain", {2'b00, p}, v);
    end
    // Gain ceiling clamps the amplifier request
    for (int i = 0; i < 8; i++) begin
      p = (i == 0) ? 6'h00 : 6'($urandom);
      w(8'h24, {2'b00, p});
      @(posedge clk_sys);
      vga_gain_request <= 6'($urandom);
      settle();
      cmp("ceiling", {2'b00, (vga_gain_request > p) ? p : vga_gain_request}, {2'b00, vga_gain_cmd});
    end
    w(8'h24, 8'h3F);
    // Configuration bits against line conditions
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      w(8'h22, d);
      @(posedge clk_sys);
      rx_level_short <= 1'($urandom);
      adc_out_of_range <= 1'($urandom);
      settle();
      cmp("update", {7'h0, !d[3] && !(d[7] && rx_level_short)}, {7'h0, eq_update_en});
      cmp("switch", {7'h0, d[1] && !(d[2] && adc_out_of_range)}, {7'h0, build_out_switch_en});
      cmp("atten", {7'h0, !d[1]}, {7'h0, attenuation_forced_off});
      cmp("slice", {7'h0, d[6]}, {7'h0, high_clock_slice_threshold});
      d = 8'($urandom);
      w(8'h27, d);
      w(8'h23, d);
      settle();
      cmp("slicer", d, {agc_max_value, agc_min_value, data_slice_threshold});
      cmp("filter", {1'b0, d[6:0]}, {1'b0, loop_filter_gain});
    end
    // Eye thresholds, restart on excess error, pulse codes
    for (int k = 0; k < 5; k++) begin
      w(8'h28, {2'(k), 2'(3 - k), (k < 4) ? 4'(9 + k) : 4'h0});
      for (int s = 0; s < 2; s++) begin
        t = tol_of(s ? 2'(3 - k) : 2'(k));
        @(posedge clk_sys);
        eq_tracking <= 1'(s);
        eq_error_pct <= t;
        settle();
        cmp("tolerance", {1'b0, t}, {1'b0, eye_tolerance_pct});
        cmp("no restart", 8'h00, {7'h0, eq_restart});
        @(posedge clk_sys);
        eq_error_pct <= t + 7'h01;
        settle();
        cmp("restart", 8'h01, {7'h0, eq_restart});
        @(posedge clk_sys);
        eq_error_pct <= 7'h00;
      end
      cmp("pulse", {1'b0, pulse_of((k < 4) ? 4'(9 + k) : 4'h0)}, {1'b0, target_pulse_pct});
    end
    i_rlec_host_model.level_default();
    // Pre-equalizer auto and forced modes
    for (int k = 0; k < 8; k++) begin
      d = {2'(k), 6'($urandom)};
      w(8'h2A, d);
      @(posedge clk_sys);
      pre_equalizer_auto_on <= k[2];
      settle();
      cmp("pre_equalizer", {7'h0, d[7] ? d[6] : k[2]}, {7'h0, pre_equalizer_on});
      cmp("pre_filter_threshold", {2'b00, d[5:0]}, {2'b00, pre_filter_threshold});
    end
    // Adjusted coefficients are read only
    @(posedge clk_sys);
    adjusted_coefficient <= {$urandom, $urandom};
    for (int i = 0; i < 8; i++) begin
      w(8'h30 + 8'(i), 8'h5C);
      rdc(8'h30 + 8'(i), adjusted_coefficient[i]);
    end
    // Gain window lengths, ticking every cycle
    for (int k = 0; k < 4; k++) begin
      w(8'h22, {2'b00, 2'(k), 4'b0011});
      gap(0, 5000, n);
      @(negedge clk_sys);
      gap(0, 5000, n);
      cmp_n("window", (32 << (2 * k)) - 1, n);
    end
    // Eye-open timeout, short and long
    for (int k = 0; k < 2; k++) begin
      w(8'h22, {7'h18, 1'(k)});
      @(posedge clk_sys);
      eye_open <= 1'b0;
      gap(1, 9000, n);
      cmp_n("timeout", 1, int'(n >= (k ? LONG_EYE : 4096) - 1 && n <= (k ? LONG_EYE : 4096) + 1));
      @(posedge clk_sys);
      eye_open <= 1'b1;
    end
    // Soft reset reloads only its own set
    w(8'h26, 8'h05);
    w(8'h25, 8'hC3);
    w(8'h27, 8'h9E);
    w(8'h2A, 8'h81);
    w(8'h24, 8'h15);
    w(8'h20, 8'h80);
    gap(2, 4, n);
    @(negedge clk_sys);
    cmp("soft pulse", 8'h00, {7'h0, line_interface_soft_reset});
    rdc(8'h26, 8'h00);
    rdc(8'h25, 8'h00);
    cmp("table", 8'h00, coefficient_table[47:40]);
    rdc(8'h27, 8'h00);
    rdc(8'h2A, 8'h00);
    rdc(8'h24, 8'h15);
    rdc(8'h20, 8'h00);
    final_report();
  end
endmodule
